/* rtl/rls_baud.v */
// Oversampling baud-rate enable generator for the serial link
`timescale 1ns/100ps
`include "rls_map.vh"
module rls_baud #(
    parameter CLK_HZ = `RLS_CLK_HZ,
    parameter OVS    = `RLS_OVS
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // Rate selection
    input  wire [2:0] baud_sel,
    // Oversample enable
    output reg        baud_tick_ff
);
    reg [15:0] div_ff;

    function [15:0] div_of;
        input [2:0] sel;
        integer     rate;
        integer     q;
        begin
            case (sel)
                `RLS_BAUD_1200:  rate = 1200;
                `RLS_BAUD_2400:  rate = 2400;
                `RLS_BAUD_4800:  rate = 4800;
                `RLS_BAUD_19200: rate = 19200;
                default:         rate = 9600;
            endcase
            q      = CLK_HZ / (rate * OVS) - 1;
            div_of = q[15:0];
        end
    endfunction

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_ff       <= 16'h0000;
            baud_tick_ff <= 1'b0;
        end else if (div_ff >= div_of(baud_sel)) begin
            div_ff       <= 16'h0000;
            baud_tick_ff <= 1'b1;
        end else begin
            div_ff       <= div_ff + 16'h0001;
            baud_tick_ff <= 1'b0;
        end
    end
endmodule

/* rtl/rls_map.vh */
// Register offsets, field positions, reset values and timing for the reference-loss block
`ifndef RLS_MAP_VH
`define RLS_MAP_VH

`define RLS_CLK_HZ        20000000
`define RLS_TICK_MS       100
`define RLS_OVS           16

`define RLS_REG_CTRL      8'h00
`define RLS_REG_OUTFN     8'h01
`define RLS_REG_MIN_A     8'h02
`define RLS_REG_MIN_B     8'h03
`define RLS_REG_MIN_C     8'h04
`define RLS_REG_WAIT      8'h05
`define RLS_REG_SERCFG    8'h06
`define RLS_REG_COMM_TO   8'h07
`define RLS_REG_STATUS    8'h08
`define RLS_REG_INT_STAT  8'h09
`define RLS_REG_INT_MASK  8'h0a

`define RLS_CRIT_OFF      2'h0
`define RLS_CRIT_HALF     2'h1
`define RLS_CRIT_FULL     2'h2

`define RLS_ACT_HOLD      2'h0
`define RLS_ACT_COAST     2'h1
`define RLS_ACT_DECEL     2'h2

`define RLS_SRC_AUX       3'h2
`define RLS_SRC_VOLT      3'h3
`define RLS_SRC_CURR      3'h4
`define RLS_SRC_VPLUSI    3'h6
`define RLS_SRC_SERIAL    3'h7
`define RLS_RUN_SERIAL    2'h3

`define RLS_OFN_REF_LOSS  5'h0b
`define RLS_RST_TR_FN     5'h0c
`define RLS_RST_RLY_FN    5'h11

`define RLS_BAUD_1200     3'h0
`define RLS_BAUD_2400     3'h1
`define RLS_BAUD_4800     3'h2
`define RLS_BAUD_9600     3'h3
`define RLS_BAUD_19200    3'h4
`define RLS_RST_BAUD      3'h3

`define RLS_RST_STATION   8'h01
`define RLS_STATION_MAX   8'hfa
`define RLS_RST_COMM_ACT  2'h0

`define RLS_TIME_MIN      11'h001
`define RLS_TIME_MAX      11'h4b0
`define RLS_RST_WAIT      11'h00a
`define RLS_RST_COMM_TO   11'h00a

`define RLS_MODE_RUN      2'h0
`define RLS_MODE_HOLD     2'h1
`define RLS_MODE_COAST    2'h2
`define RLS_MODE_DECEL    2'h3

`define RLS_INT_FREQ_LOSS 0
`define RLS_INT_COMM_LOST 1
`define RLS_INT_FRAME     2

`endif

/* rtl/rls_top.v */
// Reference-loss supervisor with serial port configuration registers
`timescale 1ns/100ps
`include "rls_map.vh"

// What this block does
// - Criterion code zero disables every analog reference loss check.
// - Criterion one flags loss below half the input's minimum level.
// - Criterion two flags loss below the input's minimum level.
// - Voltage-plus-current source is lost when either input is below its minimum.
// - Loss action applies only after the full wait time without valid reference.
// - Action zero holds frequency, one coasts, two decelerates to stop.
// - Output function eleven drives that output while frequency loss holds.
// - Run control from serial at run source three, frequency at source seven.
// - Station number 1 to 250, unique; only own-station frames are answered.
// - Baud selector picks 19200 down to 1200; code three is 9600, the default.
// - Protocol zero is binary RTU framing, one is bracketed ASCII framing.
// - No parity; two stop bits for RTU, one for ASCII, same at both ends.
// - Communication-loss action resets to zero, meaning no action.
// - Communication timeout resets to 1.0 s of silence before loss.
// - Loss wait time ranges 0.1 to 120 s, default 1.0 s.
module rls_top #(
    parameter CLK_HZ      = `RLS_CLK_HZ,
    parameter TICK_CYCLES = `RLS_CLK_HZ / 1000 * `RLS_TICK_MS,
    parameter AW          = 12
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          rst_n,
    // Register port
    input  wire [7:0]    reg_addr,
    input  wire [15:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [15:0]   reg_rdata_ff,
    // Measured analog references
    input  wire [AW-1:0] aux_ref_input,
    input  wire [AW-1:0] voltage_ref_input,
    input  wire [AW-1:0] current_ref_input,
    // Serial framer results
    input  wire          frame_done,
    input  wire          frame_ok,
    input  wire [7:0]    frame_station,
    output reg           frame_accept_ff,
    // Serial port setup
    output wire          baud_tick,
    output reg           proto_ascii_ff,
    output reg           stop_bits_two_ff,
    output reg           run_cmd_serial_ff,
    output reg           freq_cmd_serial_ff,
    // Drive control and indication
    output reg  [1:0]    drive_mode_ff,
    output reg           transistor_output_ff,
    output reg           relay_contacts_ff,
    output reg           freq_loss_ff,
    output wire          comm_lost,
    // Interrupt
    output wire          irq
);
    localparam integer TICK_M1   = TICK_CYCLES - 1;
    localparam [21:0]  TICK_LAST = TICK_M1[21:0];

    reg  [1:0]    loss_criterion_sel_ff;
    reg  [1:0]    loss_action_sel_ff;
    reg  [2:0]    freq_source_sel_ff;
    reg  [1:0]    run_cmd_source_ff;
    reg  [4:0]    transistor_output_func_ff;
    reg  [4:0]    relay_output_func_ff;
    reg  [AW-1:0] ref_min_level_a_ff;
    reg  [AW-1:0] ref_min_level_b_ff;
    reg  [AW-1:0] ref_min_level_c_ff;
    reg  [10:0]   loss_wait_time_ff;
    reg           proto_sel_ff;
    reg  [2:0]    baud_sel_ff;
    reg  [1:0]    comm_action_sel_ff;
    reg  [7:0]    station_ff;
    reg  [10:0]   comm_timeout_ff;
    reg  [2:0]    int_stat_ff;
    reg  [2:0]    int_mask_ff;
    reg  [2:0]    nxt_int_stat;
    reg  [21:0]   tick_cnt_ff;
    reg           tick_ff;
    reg           ref_raw_loss;
    reg           ref_lost_ff;
    reg           comm_lost_q_ff;
    reg  [1:0]    nxt_drive_mode;
    reg  [15:0]   nxt_rdata;
    wire          ref_expired;
    wire          wr_int_stat;
    wire          frame_hit;
    wire          station_legal;
    wire          analog_lost;
    wire [2:0]    events;

    // Below-minimum test shared by all three analog inputs
    function below_min;
        input [1:0]    crit;
        input [AW-1:0] val;
        input [AW-1:0] lim;
        begin
            case (crit)
                `RLS_CRIT_HALF: below_min = (val < (lim >> 1));
                `RLS_CRIT_FULL: below_min = (val < lim);
                default:        below_min = 1'b0;
            endcase
        end
    endfunction

    // Out-of-range time writes are pulled into the legal span
    function [10:0] clamp_time;
        input [15:0] v;
        begin
            if (v < {5'h00, `RLS_TIME_MIN})
                clamp_time = `RLS_TIME_MIN;
            else if (v > {5'h00, `RLS_TIME_MAX})
                clamp_time = `RLS_TIME_MAX;
            else
                clamp_time = v[10:0];
        end
    endfunction

    // Register writes
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loss_criterion_sel_ff     <= `RLS_CRIT_OFF;
            loss_action_sel_ff        <= `RLS_ACT_HOLD;
            freq_source_sel_ff        <= 3'h0;
            run_cmd_source_ff         <= 2'h0;
            transistor_output_func_ff <= `RLS_RST_TR_FN;
            relay_output_func_ff      <= `RLS_RST_RLY_FN;
            ref_min_level_a_ff        <= {AW{1'b0}};
            ref_min_level_b_ff        <= {AW{1'b0}};
            ref_min_level_c_ff        <= {AW{1'b0}};
            loss_wait_time_ff         <= `RLS_RST_WAIT;
            proto_sel_ff              <= 1'b0;
            baud_sel_ff               <= `RLS_RST_BAUD;
            comm_action_sel_ff        <= `RLS_RST_COMM_ACT;
            station_ff                <= `RLS_RST_STATION;
            comm_timeout_ff           <= `RLS_RST_COMM_TO;
            int_mask_ff               <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `RLS_REG_CTRL: begin
                    loss_criterion_sel_ff <= reg_wdata[1:0];
                    loss_action_sel_ff    <= reg_wdata[3:2];
                    freq_source_sel_ff    <= reg_wdata[6:4];
                    run_cmd_source_ff     <= reg_wdata[9:8];
                end
                `RLS_REG_OUTFN: begin
                    transistor_output_func_ff <= reg_wdata[4:0];
                    relay_output_func_ff      <= reg_wdata[12:8];
                end
                `RLS_REG_MIN_A:   ref_min_level_a_ff <= reg_wdata[AW-1:0];
                `RLS_REG_MIN_B:   ref_min_level_b_ff <= reg_wdata[AW-1:0];
                `RLS_REG_MIN_C:   ref_min_level_c_ff <= reg_wdata[AW-1:0];
                `RLS_REG_WAIT:    loss_wait_time_ff  <= clamp_time(reg_wdata);
                `RLS_REG_SERCFG: begin
                    proto_sel_ff       <= reg_wdata[0];
                    baud_sel_ff        <= reg_wdata[3:1];
                    comm_action_sel_ff <= reg_wdata[5:4];
                    station_ff         <= reg_wdata[15:8];
                end
                `RLS_REG_COMM_TO: comm_timeout_ff <= clamp_time(reg_wdata);
                `RLS_REG_INT_MASK: int_mask_ff    <= reg_wdata[2:0];
                default: begin
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `RLS_REG_CTRL:     nxt_rdata = {6'h00, run_cmd_source_ff, 1'b0, freq_source_sel_ff,
                                            loss_action_sel_ff, loss_criterion_sel_ff};
            `RLS_REG_OUTFN:    nxt_rdata = {3'h0, relay_output_func_ff,
                                            3'h0, transistor_output_func_ff};
            `RLS_REG_MIN_A:    nxt_rdata[AW-1:0] = ref_min_level_a_ff;
            `RLS_REG_MIN_B:    nxt_rdata[AW-1:0] = ref_min_level_b_ff;
            `RLS_REG_MIN_C:    nxt_rdata[AW-1:0] = ref_min_level_c_ff;
            `RLS_REG_WAIT:     nxt_rdata = {5'h00, loss_wait_time_ff};
            `RLS_REG_SERCFG:   nxt_rdata = {station_ff, 2'h0, comm_action_sel_ff,
                                            baud_sel_ff, proto_sel_ff};
            `RLS_REG_COMM_TO:  nxt_rdata = {5'h00, comm_timeout_ff};
            `RLS_REG_STATUS:   nxt_rdata = {12'h000, stop_bits_two_ff, comm_lost,
                                            freq_loss_ff, ref_raw_loss};
            `RLS_REG_INT_STAT: nxt_rdata = {13'h0000, int_stat_ff};
            `RLS_REG_INT_MASK: nxt_rdata = {13'h0000, int_mask_ff};
            default:           nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_ff <= 16'h0000;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
        else
            reg_rdata_ff <= 16'h0000;
    end

    // Tenth-of-a-second enable for both timers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 22'h000000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff >= TICK_LAST) begin
            tick_cnt_ff <= 22'h000000;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 22'h000001;
            tick_ff     <= 1'b0;
        end
    end

    // Serial setup
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            proto_ascii_ff     <= 1'b0;
            stop_bits_two_ff   <= 1'b1;
            run_cmd_serial_ff  <= 1'b0;
            freq_cmd_serial_ff <= 1'b0;
        end else begin
            proto_ascii_ff     <= proto_sel_ff;
            stop_bits_two_ff   <= ~proto_sel_ff;
            run_cmd_serial_ff  <= (run_cmd_source_ff == `RLS_RUN_SERIAL);
            freq_cmd_serial_ff <= (freq_source_sel_ff == `RLS_SRC_SERIAL);
        end
    end

    rls_baud #(
        .CLK_HZ       (CLK_HZ),
        .OVS          (`RLS_OVS)
    ) u_baud (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .baud_sel     (baud_sel_ff),
        .baud_tick_ff (baud_tick)
    );

    // Station 0 and numbers above 250 never match, so a bad setup stays silent
    assign station_legal = (station_ff != 8'h00) && (station_ff <= `RLS_STATION_MAX);
    assign frame_hit     = frame_done && frame_ok && station_legal &&
                           (frame_station == station_ff);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            frame_accept_ff <= 1'b0;
        else
            frame_accept_ff <= frame_hit;
    end

    // Link silence timer restarts on every accepted frame
    rls_wait #(
        .W          (11)
    ) u_comm_wait (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .run        (~frame_hit),
        .tick       (tick_ff),
        .limit      (comm_timeout_ff),
        .expired_ff (comm_lost)
    );

    // Raw reference loss by selected source
    assign analog_lost = below_min(loss_criterion_sel_ff, voltage_ref_input,
                                   ref_min_level_b_ff);

    always @* begin
        case (freq_source_sel_ff)
            `RLS_SRC_AUX:    ref_raw_loss = below_min(loss_criterion_sel_ff, aux_ref_input,
                                                      ref_min_level_a_ff);
            `RLS_SRC_VOLT:   ref_raw_loss = analog_lost;
            `RLS_SRC_CURR:   ref_raw_loss = below_min(loss_criterion_sel_ff, current_ref_input,
                                                      ref_min_level_c_ff);
            `RLS_SRC_VPLUSI: ref_raw_loss = analog_lost ||
                                            below_min(loss_criterion_sel_ff, current_ref_input,
                                                      ref_min_level_c_ff);
            `RLS_SRC_SERIAL: ref_raw_loss = comm_lost;
            default:         ref_raw_loss = 1'b0;
        endcase
    end

    rls_wait #(
        .W          (11)
    ) u_ref_wait (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .run        (ref_raw_loss),
        .tick       (tick_ff),
        .limit      (loss_wait_time_ff),
        .expired_ff (ref_expired)
    );

    // Drive mode; coast outranks decel, decel outranks hold
    always @* begin
        nxt_drive_mode = `RLS_MODE_RUN;
        if ((ref_expired && loss_action_sel_ff == `RLS_ACT_COAST) ||
            (comm_lost && comm_action_sel_ff == `RLS_ACT_COAST))
            nxt_drive_mode = `RLS_MODE_COAST;
        else if ((ref_expired && loss_action_sel_ff == `RLS_ACT_DECEL) ||
                 (comm_lost && comm_action_sel_ff == `RLS_ACT_DECEL))
            nxt_drive_mode = `RLS_MODE_DECEL;
        else if (ref_expired && loss_action_sel_ff == `RLS_ACT_HOLD)
            nxt_drive_mode = `RLS_MODE_HOLD;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freq_loss_ff         <= 1'b0;
            drive_mode_ff        <= `RLS_MODE_RUN;
            transistor_output_ff <= 1'b0;
            relay_contacts_ff    <= 1'b0;
            ref_lost_ff          <= 1'b0;
            comm_lost_q_ff       <= 1'b0;
        end else begin
            freq_loss_ff         <= ref_expired;
            drive_mode_ff        <= nxt_drive_mode;
            transistor_output_ff <= ref_expired &&
                                    (transistor_output_func_ff == `RLS_OFN_REF_LOSS);
            relay_contacts_ff    <= ref_expired &&
                                    (relay_output_func_ff == `RLS_OFN_REF_LOSS);
            ref_lost_ff          <= ref_expired;
            comm_lost_q_ff       <= comm_lost;
        end
    end

    // Sticky events; a new event beats a simultaneous write-one clear
    assign events      = {frame_hit, comm_lost & ~comm_lost_q_ff, ref_expired & ~ref_lost_ff};
    assign wr_int_stat = reg_wr && (reg_addr == `RLS_REG_INT_STAT);

    always @* begin
        nxt_int_stat = int_stat_ff;
        if (wr_int_stat)
            nxt_int_stat = nxt_int_stat & ~reg_wdata[2:0];
        nxt_int_stat = nxt_int_stat | events;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            int_stat_ff <= 3'h0;
        else
            int_stat_ff <= nxt_int_stat;
    end

    assign irq = |(int_stat_ff & int_mask_ff);
endmodule

/* rtl/rls_wait.v */
// Tick-counting wait timer that reports expiry of a programmable limit
`timescale 1ns/100ps
module rls_wait #(
    parameter W = 11
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst_n,
    // Control
    input  wire         run,
    input  wire         tick,
    input  wire [W-1:0] limit,
    // Result
    output reg          expired_ff
);
    reg [W-1:0] cnt_ff;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff     <= {W{1'b0}};
            expired_ff <= 1'b0;
        end else if (!run) begin
            // Clearing at once lets a returning reference end the loss
            cnt_ff     <= {W{1'b0}};
            expired_ff <= 1'b0;
        end else begin
            // One extra tick: the free-running tick must never cut the wait short
            if (tick && (cnt_ff <= limit))
                cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
            expired_ff <= (cnt_ff > limit);
        end
    end
endmodule

/* tb/rls_assertions.sv */
// Port-level checker for the reference-loss supervisor
`timescale 1ns/100ps
`include "rls_map.vh"
module rls_checker (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Serial side
    input wire       frame_done,
    input wire       frame_ok,
    input wire [7:0] frame_station,
    input wire       frame_accept_ff,
    input wire       baud_tick,
    input wire       proto_ascii_ff,
    input wire       stop_bits_two_ff,
    // Drive side
    input wire [1:0] drive_mode_ff,
    input wire       transistor_output_ff,
    input wire       relay_contacts_ff,
    input wire       freq_loss_ff,
    input wire       comm_lost
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    accept_good_frame_a: assert property (frame_accept_ff |-> $past(frame_done && frame_ok))
        else $error("accept without a good frame");
    accept_station_range_a: assert property
        (frame_accept_ff |-> $past(frame_station) inside {[8'h01:8'hfa]})
        else $error("accept for station outside 1..250");
    stop_bits_proto_a: assert property (stop_bits_two_ff != proto_ascii_ff)
        else $error("stop bits do not follow protocol");
    tr_out_loss_a: assert property (transistor_output_ff |-> freq_loss_ff)
        else $error("transistor output without loss");
    relay_out_loss_a: assert property (relay_contacts_ff |-> freq_loss_ff)
        else $error("relay output without loss");
    loss_mode_act_a: assert property (freq_loss_ff |-> drive_mode_ff != `RLS_MODE_RUN)
        else $error("loss in effect but mode is run");
    run_when_clear_a: assert property
        (!freq_loss_ff && !comm_lost && !$past(comm_lost) |-> drive_mode_ff == `RLS_MODE_RUN)
        else $error("mode not run with no loss");
    baud_single_pulse_a: assert property (baud_tick |=> !baud_tick)
        else $error("baud tick longer than one cycle");

    cover property ($rose(freq_loss_ff));
    cover property (frame_accept_ff);
    cover property (proto_ascii_ff && baud_tick);
endmodule

bind rls_top rls_checker u_chk (.clk_sys, .rst_n, .frame_done, .frame_ok, .frame_station,
    .frame_accept_ff, .baud_tick, .proto_ascii_ff, .stop_bits_two_ff, .drive_mode_ff,
    .transistor_output_ff, .relay_contacts_ff, .freq_loss_ff, .comm_lost);

/* tb/rls_master_model.sv */
// Bus master model that hands finished frames to the supervisor
`timescale 1ns/100ps
module rls_master_model (
    // Clock
    input  wire       clk_sys,
    // Framer results
    output reg        frame_done,
    output reg        frame_ok,
    output reg  [7:0] frame_station
);
    reg sending = 1'b0;

    initial begin
        frame_done    = 1'b0;
        frame_ok      = 1'b0;
        frame_station = 8'h00;
    end

    // Idle lines wander so a stale address never passes for a live one
    always @(posedge clk_sys) begin
        if (!sending) begin
            frame_station <= ~frame_station;
            frame_ok      <= ~frame_ok;
        end
    end

    // One frame per call, addressed to a single station; bad ones flagged
    task send(input [7:0] st, input ok);
        begin
            sending = 1'b1;
            @(posedge clk_sys);
            frame_done    <= 1'b1;
            frame_ok      <= ok;
            frame_station <= st;
            @(posedge clk_sys);
            frame_done <= 1'b0;
            sending = 1'b0;
        end
    endtask
endmodule

/* tb/rls_top_tb.sv */
// Self-checking bench for the reference-loss supervisor
`timescale 1ns/100ps
`include "rls_map.vh"
module rls_top_tb;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [11:0] aux_ref_input = 12'hfff;
    reg  [11:0] voltage_ref_input = 12'hfff;
    reg  [11:0] current_ref_input = 12'hfff;
    wire [15:0] reg_rdata_ff;
    wire        frame_done, frame_ok, frame_accept_ff, baud_tick, proto_ascii_ff;
    wire        stop_bits_two_ff, run_cmd_serial_ff, freq_cmd_serial_ff, irq;
    wire        transistor_output_ff, relay_contacts_ff, freq_loss_ff, comm_lost;
    wire [7:0]  frame_station;
    wire [1:0]  drive_mode_ff;
    integer     num_errors = 0, checks_done = 0, cyc = 0;
    integer     i, c, k, a, n, hits, t0, want;
    reg  [15:0] rv;
    reg  [11:0] m, v;
    reg  [7:0]  s;
    reg         exp;

    // Short tick keeps the 0.1 s steps affordable
    rls_top #(.TICK_CYCLES(20)) dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_ff, .aux_ref_input, .voltage_ref_input, .current_ref_input,
        .frame_done, .frame_ok, .frame_station, .frame_accept_ff, .baud_tick, .proto_ascii_ff,
        .stop_bits_two_ff, .run_cmd_serial_ff, .freq_cmd_serial_ff, .drive_mode_ff,
        .transistor_output_ff, .relay_contacts_ff, .freq_loss_ff, .comm_lost, .irq);

    rls_master_model mst (.clk_sys, .frame_done, .frame_ok, .frame_station);

    always #25 clk_sys = ~clk_sys;

    task close_out;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            close_out;
        end
    end

    task chk(input [15:0] got, input [15:0] wnt, input [8*12-1:0] what);
        begin
            checks_done = checks_done + 1;
            if (got !== wnt) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED at %0t: %0s got %h want %h", $time, what, got, wnt);
            end
        end
    endtask

    // Steps end 1 ns past the edge so flop outputs have settled
    task cycles(input integer cnt);
        begin
            repeat (cnt) @(posedge clk_sys);
            #1;
        end
    endtask

    task wr(input [7:0] ad, input [15:0] d);
        begin
            reg_addr <= ad;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            cycles(1);
        end
    endtask

    task rd(input [7:0] ad, output [15:0] d);
        begin
            reg_addr <= ad;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 d = reg_rdata_ff;
        end
    endtask

    function [15:0] rst_val(input integer r);
        case (r)
            1: rst_val = 16'h110c;
            5, 7: rst_val = 16'h000a;
            6: rst_val = 16'h0106;
            default: rst_val = 16'h0000;
        endcase
    endfunction

    initial begin
        rv = $urandom(32);
        cycles(5);
        rst_n = 1'b1;
        for (i = 0; i < 9; i = i + 1) begin
            rd(i == 8 ? 8'h0f : i[7:0], rv);
            chk(rv, rst_val(i == 8 ? 15 : i), "reset value");
        end
        chk(stop_bits_two_ff, 1, "reset stop");
        chk(proto_ascii_ff, 0, "reset proto");
        wr(`RLS_REG_WAIT, 16'h0000);
        rd(`RLS_REG_WAIT, rv);
        chk(rv, 16'h0001, "wait floor");
        wr(`RLS_REG_WAIT, 16'h07ff);
        rd(`RLS_REG_WAIT, rv);
        chk(rv, 16'h04b0, "wait ceiling");
        wr(`RLS_REG_WAIT, 16'h0002);
        wr(`RLS_REG_OUTFN, {3'h0, `RLS_OFN_REF_LOSS, 3'h0, `RLS_OFN_REF_LOSS});
        wr(`RLS_REG_INT_MASK, 16'h0001);
        m = 12'(400 + 2 * ($urandom % 800));
        wr(`RLS_REG_MIN_B, {4'h0, m});
        // Probe just under half, just over half and exactly at the minimum
        for (c = 0; c < 3; c = c + 1) begin
            for (k = 0; k < 3; k = k + 1) begin
                v = (k == 0) ? (m >> 1) - 12'd1 : (k == 1) ? (m >> 1) + 12'd1 : m;
                a = (c + k) % 3;
                wr(`RLS_REG_CTRL, 16'(`RLS_SRC_VOLT * 16 + a * 4 + c));
                voltage_ref_input <= v;
                exp = (c == 1 && v < (m >> 1)) || (c == 2 && v < m);
                cycles(39);
                chk(freq_loss_ff, 0, "early loss");
                cycles(29);
                chk(freq_loss_ff, exp, "loss flag");
                chk(transistor_output_ff, exp, "tr output");
                chk(relay_contacts_ff, exp, "relay");
                chk(drive_mode_ff, exp ? a + 1 : 0, "drive mode");
                chk(irq, exp, "irq raised");
                voltage_ref_input <= 12'hfff;
                cycles(3);
                chk(freq_loss_ff, 0, "loss clear");
                wr(`RLS_REG_INT_STAT, 16'h0007);
                chk(irq, 0, "irq clear");
            end
        end
        wr(`RLS_REG_MIN_C, {4'h0, m});
        wr(`RLS_REG_INT_MASK, 16'h0000);
        wr(`RLS_REG_CTRL, 16'(`RLS_SRC_VPLUSI * 16 + 2));
        current_ref_input <= m - 12'd1;
        cycles(70);
        chk(freq_loss_ff, 1, "v+i loss");
        chk(irq, 0, "masked");
        wr(`RLS_REG_INT_MASK, 16'h0001);
        chk(irq, 1, "unmasked");
        wr(`RLS_REG_INT_STAT, 16'h0001);
        chk(irq, 0, "stat clear");
        current_ref_input <= 12'hfff;
        s = 8'(2 + $urandom % 249);
        for (c = 0; c < 5; c = c + 1) begin
            wr(`RLS_REG_SERCFG, {s, 4'h0, c[2:0], 1'b0});
            hits = 0;
            n = 0;
            while (hits < 3 && n < 4000) begin
                cycles(1);
                n = n + 1;
                if (baud_tick === 1'b1) begin
                    hits = hits + 1;
                    t0 = (hits == 2) ? n : t0;
                end
            end
            want = `RLS_CLK_HZ / (`RLS_OVS * (1200 << c));
            chk(n - t0 >= want - 1 && n - t0 <= want + 1, 1, "baud period");
        end
        wr(`RLS_REG_SERCFG, {s, 4'h0, `RLS_BAUD_19200, 1'b1});
        chk(proto_ascii_ff, 1, "ascii");
        chk(stop_bits_two_ff, 0, "one stop");
        for (k = 0; k < 3; k = k + 1) begin
            mst.send(k == 1 ? s - 8'd1 : s, k != 2);
            #1 chk(frame_accept_ff, k == 0, "accept");
        end
        rd(`RLS_REG_INT_STAT, rv);
        chk(rv & 16'h0004, 16'h0004, "frame stat");
        wr(`RLS_REG_CTRL, 16'(`RLS_RUN_SERIAL * 256 + `RLS_SRC_SERIAL * 16));
        chk(run_cmd_serial_ff, 1, "run serial");
        chk(freq_cmd_serial_ff, 1, "freq serial");
        mst.send(s, 1'b1);
        cycles(100);
        chk(comm_lost, 0, "link alive");
        cycles(150);
        chk(comm_lost, 1, "link lost");
        cycles(70);
        chk(freq_loss_ff, 1, "serial loss");
        chk(drive_mode_ff, `RLS_MODE_HOLD, "hold mode");
        close_out;
    end
endmodule
